// File: rtl/systk_cfg.svh
// constants of the system tick down counter
// Summary of operation
// [RULE_01] 24-bit down counter, secure and non-secure copies
// [RULE_02] decrement to zero, then load reload value
// [RULE_03] zero reload stops counting at next wrap
// [RULE_04] wrap flag bit 16 set on one-to-zero
// [RULE_05] control/status read returns and clears flag
// [RULE_06] current value write clears count and flag
// [RULE_07] software clear raises no tick request
// [RULE_08] current value reads live count, upper zero
// [RULE_09] debug halt holds the count
// [RULE_10] bit 2 selects processor or reference clock
// [RULE_11] bit 1 lets zero raise tick request
// [RULE_12] bit 0 enables counting
// [RULE_13] reload holds 24 bits, upper bits zero
// [RULE_14] reload should be 1 to 0xFFFFFF
// [RULE_15] period of N needs reload N-1
// [RULE_16] calibration reads bits 31, 30 set, rest zero
// [RULE_17] counting stops while the clock is gated
// [RULE_18] only full word accesses allowed
// [RULE_19] program reload, clear current, then control
// [RULE_20] every register except calibration banked per security state; calibration reads one shared value in both states
// [RULE_21] tick request pulses in the zero-reaching cycle
`ifndef SYSTK_CFG_SVH
`define SYSTK_CFG_SVH
`define SYSTK_ADDR_CSR      32'hE000E010
`define SYSTK_ADDR_RVR      32'hE000E014
`define SYSTK_ADDR_CVR      32'hE000E018
`define SYSTK_ADDR_CALIB    32'hE000E01C
`define SYSTK_CNT_W         24
`define SYSTK_BIT_ENABLE    0
`define SYSTK_BIT_IRQ_EN    1
`define SYSTK_BIT_CLK_SEL   2
`define SYSTK_BIT_WRAP      16
`define SYSTK_CSR_RESET     32'h00000000
`define SYSTK_CALIB_VALUE   32'hC0000000
`define SYSTK_CNT_RESET     24'h000000
`endif

// File: rtl/systk_pkg.sv
// types of the system tick down counter
package systk_pkg;
	typedef logic [23:0] systk_count_t;
	typedef logic [31:0] systk_word_t;
	typedef enum logic [1:0] {SYSTK_IDLE, SYSTK_WRITE, SYSTK_READ, SYSTK_DONE} systk_host_state_t;
endpackage

// File: rtl/systk_if.sv
// register access link between bus side and timer
`timescale 1ns/1ps
interface systk_if;
	import systk_pkg::*;
	logic        sel;
	logic        write;
	logic        secure;
	systk_word_t addr;
	systk_word_t wdata;
	systk_word_t rdata;
	logic        tick_req_s;
	logic        tick_req_ns;
	modport dev
	(
		input  sel, write, secure, addr, wdata,
		output rdata, tick_req_s, tick_req_ns
	);
	modport host
	(
		output sel, write, secure, addr, wdata,
		input  rdata, tick_req_s, tick_req_ns
	);
endinterface

// File: rtl/systk_bank.sv
// one banked counter with its register set
`timescale 1ns/1ps
`include "systk_cfg.svh"
module systk_bank
(
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_resetn,
	input  wire logic                  i_ref_tick,
	input  wire logic                  i_halted,
	input  wire logic                  i_wr_csr,
	input  wire logic                  i_wr_rvr,
	input  wire logic                  i_wr_cvr,
	input  wire logic                  i_rd_csr,
	input  wire systk_pkg::systk_word_t i_wdata,
	output logic [2:0]                 o_ctrl,
	output logic                       o_wrap_flag,
	output systk_pkg::systk_count_t    o_reload,
	output systk_pkg::systk_count_t    o_count,
	output logic                       o_tick_req
);
	import systk_pkg::*;
	logic         step;
	logic         hit_zero;
	systk_count_t next_count;

	// count clock: processor clock or reference tick, held in debug
	assign step = o_ctrl[`SYSTK_BIT_ENABLE] && !i_halted                    // RULE_12 RULE_09
		&& (o_ctrl[`SYSTK_BIT_CLK_SEL] ? 1'b1 : i_ref_tick);            // RULE_10
	assign hit_zero = step && (o_count == 24'h000001);                      // RULE_04

	always_comb
	begin
		next_count = o_count;
		if (step)
		begin
			if (o_count == 24'h000000)
				next_count = o_reload;                              // RULE_02 RULE_03 RULE_13 RULE_14
			else
				next_count = o_count - 24'h000001;                          // RULE_01 RULE_02
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_ctrl <= 3'h0;
		else if (i_wr_csr)
			o_ctrl <= i_wdata[2:0];                                          // RULE_10 RULE_11 RULE_12
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_reload <= `SYSTK_CNT_RESET;
		else if (i_wr_rvr)
			o_reload <= i_wdata[23:0];                                       // RULE_13
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_count <= `SYSTK_CNT_RESET;
		else if (i_wr_cvr)
			o_count <= 24'h000000;                                           // RULE_06
		else
			o_count <= next_count;
	end

	// a wrap in the same cycle as a clearing read wins
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_wrap_flag <= 1'b0;
		else if (hit_zero && !i_wr_cvr)
			o_wrap_flag <= 1'b1;                                             // RULE_04
		else if (i_rd_csr || i_wr_cvr)
			o_wrap_flag <= 1'b0;                                             // RULE_05 RULE_06
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_tick_req <= 1'b0;
		else
			o_tick_req <= hit_zero && !i_wr_cvr && o_ctrl[`SYSTK_BIT_IRQ_EN]; // RULE_11 RULE_07 RULE_21
	end
endmodule

// File: rtl/systk_timer.sv
// system tick timer device end with two banks
`timescale 1ns/1ps
`include "systk_cfg.svh"
module systk_timer
(
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	input  wire logic i_ref_clk,
	input  wire logic i_halted,
	systk_if.dev      bus
);
	import systk_pkg::*;
	logic             ref_s1;
	logic             ref_s2;
	logic             ref_s3;
	logic             ref_tick;
	logic             halt_s1;
	logic             halt_s2;
	logic             acc_rd;
	logic             acc_wr;
	logic             hit_csr;
	logic             hit_rvr;
	logic             hit_cvr;
	logic             hit_calib;
	logic [1:0]       bank_on;
	logic [1:0]       wr_csr;
	logic [1:0]       wr_rvr;
	logic [1:0]       wr_cvr;
	logic [1:0]       rd_csr;
	logic [2:0]       ctrl [2];
	logic [1:0]       flag;
	systk_count_t     reload [2];
	systk_count_t     count [2];
	logic [1:0]       tick;
	systk_word_t      next_rdata;
	logic             bk;

	// reference clock pin: two stages, the third only finds the rising edge
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
			ref_s3 <= 1'b0;
		end
		else
		begin
			ref_s1 <= i_ref_clk;
			ref_s2 <= ref_s1;
			ref_s3 <= ref_s2;
		end
	end
	assign ref_tick = ref_s2 && !ref_s3;                                   // RULE_10

	// debug halt level, two stages, so the hold starts two cycles late
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			halt_s1 <= 1'b0;
			halt_s2 <= 1'b0;
		end
		else
		begin
			halt_s1 <= i_halted;
			halt_s2 <= halt_s1;                                            // RULE_09
		end
	end

	// only full words at the four offsets are decoded
	assign acc_rd = bus.sel && !bus.write;
	assign acc_wr = bus.sel && bus.write;

	always_comb
	begin
		hit_csr   = 1'b0;
		hit_rvr   = 1'b0;
		hit_cvr   = 1'b0;
		hit_calib = 1'b0;
		unique case (bus.addr)
			`SYSTK_ADDR_CSR:   hit_csr   = 1'b1;
			`SYSTK_ADDR_RVR:   hit_rvr   = 1'b1;
			`SYSTK_ADDR_CVR:   hit_cvr   = 1'b1;
			`SYSTK_ADDR_CALIB: hit_calib = 1'b1;
			default:           hit_csr   = 1'b0;
		endcase
	end

	// bank 1 is secure, bank 0 non-secure; both share the offsets
	assign bk = bus.secure;                                                 // RULE_20

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_bank
			assign bank_on[g] = (bk == 1'(g));                             // RULE_01 RULE_20
			assign wr_csr[g]  = acc_wr && bank_on[g] && hit_csr;
			assign wr_rvr[g]  = acc_wr && bank_on[g] && hit_rvr;
			assign wr_cvr[g]  = acc_wr && bank_on[g] && hit_cvr;
			assign rd_csr[g]  = acc_rd && bank_on[g] && hit_csr;            // RULE_05
			systk_bank u_bank
			(
				.i_sys_clk   (i_sys_clk),
				.i_resetn    (i_resetn),
				.i_ref_tick  (ref_tick),
				.i_halted    (halt_s2),
				.i_wr_csr    (wr_csr[g]),
				.i_wr_rvr    (wr_rvr[g]),
				.i_wr_cvr    (wr_cvr[g]),
				.i_rd_csr    (rd_csr[g]),
				.i_wdata     (bus.wdata),
				.o_ctrl      (ctrl[g]),
				.o_wrap_flag (flag[g]),
				.o_reload    (reload[g]),
				.o_count     (count[g]),
				.o_tick_req  (tick[g])
			);
		end
	endgenerate

	always_comb
	begin
		next_rdata = 32'h00000000;
		unique case (bus.addr)
			`SYSTK_ADDR_CSR:   next_rdata = {15'h0000, flag[bk], 13'h0000, ctrl[bk]}; // RULE_05
			`SYSTK_ADDR_RVR:   next_rdata = {8'h00, reload[bk]};                    // RULE_13
			`SYSTK_ADDR_CVR:   next_rdata = {8'h00, count[bk]};                     // RULE_08
			`SYSTK_ADDR_CALIB: next_rdata = `SYSTK_CALIB_VALUE;                     // RULE_16
			default:           next_rdata = 32'h00000000;
		endcase
	end

	// read data registered one cycle after the read strobe
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			bus.rdata <= 32'h00000000;
		else if (bus.sel && !bus.write)
			bus.rdata <= next_rdata;
	end

	// gating i_sys_clk stops the counter as well
	assign bus.tick_req_s  = tick[1];                                       // RULE_17 RULE_21
	assign bus.tick_req_ns = tick[0];                                       // RULE_21
endmodule

// File: rtl/systk_host.sv
// processor side: word accesses to the timer registers
`timescale 1ns/1ps
`include "systk_cfg.svh"
module systk_host
(
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_resetn,
	input  wire logic                   i_req,
	input  wire logic                   i_req_write,
	input  wire logic                   i_req_secure,
	input  wire systk_pkg::systk_word_t i_req_addr,
	input  wire systk_pkg::systk_word_t i_req_wdata,
	output logic                        o_busy,
	output logic                        o_done,
	output systk_pkg::systk_word_t      o_rdata,
	output logic                        o_tick_s,
	output logic                        o_tick_ns,
	systk_if.host                       bus
);
	import systk_pkg::*;
	systk_host_state_t state;

	// one full-word access per request
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			state <= SYSTK_IDLE;
		else
		begin
			unique case (state)
				SYSTK_IDLE:  if (i_req) state <= i_req_write ? SYSTK_WRITE : SYSTK_READ; // RULE_18
				SYSTK_WRITE: state <= SYSTK_IDLE;
				SYSTK_READ:  state <= SYSTK_DONE;
				SYSTK_DONE:  state <= SYSTK_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			bus.addr   <= 32'h00000000;
			bus.wdata  <= 32'h00000000;
			bus.secure <= 1'b0;
		end
		else if (state == SYSTK_IDLE && i_req)
		begin
			bus.addr   <= i_req_addr;
			bus.wdata  <= i_req_wdata;
			bus.secure <= i_req_secure;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_rdata <= 32'h00000000;
		else if (state == SYSTK_DONE)
			o_rdata <= bus.rdata;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_tick_s  <= 1'b0;
			o_tick_ns <= 1'b0;
		end
		else
		begin
			o_tick_s  <= bus.tick_req_s;
			o_tick_ns <= bus.tick_req_ns;
		end
	end

	assign bus.sel   = (state == SYSTK_WRITE) || (state == SYSTK_READ);
	assign bus.write = (state == SYSTK_WRITE);
	assign o_busy    = (state != SYSTK_IDLE);
	assign o_done    = (state == SYSTK_WRITE) || (state == SYSTK_DONE);
endmodule

// File: dv/systk_assertions.sv
// checker on the link between host end and timer end
`timescale 1ns/1ps
`include "systk_cfg.svh"
module systk_assertions
(
	input wire logic                   i_sys_clk,
	input wire logic                   i_resetn,
	input wire logic                   sel,
	input wire logic                   write,
	input wire logic                   secure,
	input wire systk_pkg::systk_word_t addr,
	input wire systk_pkg::systk_word_t wdata,
	input wire systk_pkg::systk_word_t rdata,
	input wire logic                   tick_req_s,
	input wire logic                   tick_req_ns
);
	import systk_pkg::*;
	logic rd;
	logic wr;
	logic ien;
	assign rd = sel && !write;
	assign wr = sel && write;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// secure bank irq enable as last written
	always_ff @(posedge i_sys_clk or negedge i_resetn)
		if (!i_resetn)
			ien <= 1'b0;
		else if (wr && secure && addr == `SYSTK_ADDR_CSR)
			ien <= wdata[1];
	property p_calib;
		rd && addr == `SYSTK_ADDR_CALIB |=> rdata == `SYSTK_CALIB_VALUE;
	endproperty
	a_calib: assert property (p_calib) else $error("calibration read wrong");
	property p_cvr_top;
		rd && addr == `SYSTK_ADDR_CVR |=> rdata[31:24] == 8'h00;
	endproperty
	a_cvr_top: assert property (p_cvr_top) else $error("count upper bits set");
	property p_rvr_top;
		rd && addr == `SYSTK_ADDR_RVR |=> rdata[31:24] == 8'h00;
	endproperty
	a_rvr_top: assert property (p_rvr_top) else $error("reload upper bits set");
	property p_csr_res;
		rd && addr == `SYSTK_ADDR_CSR |=> rdata[31:17] == 15'h0000 && rdata[15:3] == 13'h0000;
	endproperty
	a_csr_res: assert property (p_csr_res) else $error("status spare bits set");
	property p_clr_s;
		wr && secure && addr == `SYSTK_ADDR_CVR |=> !tick_req_s ##1 !tick_req_s;
	endproperty
	a_clr_s: assert property (p_clr_s) else $error("clear raised secure tick");
	property p_clr_ns;
		wr && !secure && addr == `SYSTK_ADDR_CVR |=> !tick_req_ns ##1 !tick_req_ns;
	endproperty
	a_clr_ns: assert property (p_clr_ns) else $error("clear raised tick");
	property p_pulse;
		tick_req_s |=> !tick_req_s;
	endproperty
	a_pulse: assert property (p_pulse) else $error("tick longer than a cycle");
	property p_ien;
		tick_req_s |-> ien || $past(ien) || $past(ien, 2);
	endproperty
	a_ien: assert property (p_ien) else $error("tick with irq disabled");
endmodule

// File: dv/test_system_tick_down_counter.sv
// self-checking bench for the tick timer pair
`timescale 1ns/1ps
`include "systk_cfg.svh"
module test_system_tick_down_counter;
	import systk_pkg::*;
	logic        clk = 0, rstn = 0, refc = 0, hlt = 0;
	logic        req = 0, wr = 0, sec = 0, busy, done, tk_s, tk_ns;
	systk_word_t ad = '0, wd = '0, rd, v;
	int          error_cnt = 0, n_tests = 0, p;
	systk_if bus_if();
	always #12.5 clk = ~clk;
	systk_timer i_systk_timer (.i_sys_clk(clk), .i_resetn(rstn), .i_ref_clk(refc),
		.i_halted(hlt), .bus(bus_if.dev));
	systk_host i_systk_host (.i_sys_clk(clk), .i_resetn(rstn), .i_req(req), .i_req_write(wr),
		.i_req_secure(sec), .i_req_addr(ad), .i_req_wdata(wd), .o_busy(busy), .o_done(done),
		.o_rdata(rd), .o_tick_s(tk_s), .o_tick_ns(tk_ns), .bus(bus_if.host));
	systk_assertions i_chk (.i_sys_clk(clk), .i_resetn(rstn), .sel(bus_if.sel),
		.write(bus_if.write), .secure(bus_if.secure), .addr(bus_if.addr),
		.wdata(bus_if.wdata), .rdata(bus_if.rdata), .tick_req_s(bus_if.tick_req_s),
		.tick_req_ns(bus_if.tick_req_ns));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input systk_word_t got, input systk_word_t exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(input logic w, input logic s, input systk_word_t a, input systk_word_t d);
		int n;
		@(negedge clk);
		{req, wr, sec, ad, wd} = {1'b1, w, s, a, d};
		@(negedge clk);
		req = 0;
		n = 0;
		chk("done", {31'h0, done}, {31'h0, w});
		while (busy !== 1'b0 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic rdc(input logic s, input systk_word_t a, input systk_word_t e, input string nm);
		acc(0, s, a, 0);
		chk(nm, rd, e);
	endtask
	task automatic period(input logic s);
		p = 0;
		while ((s ? tk_s : tk_ns) !== 1'b1 && p < 40)
		begin
			@(negedge clk);
			p++;
		end
		@(negedge clk);
		p = 1;
		while ((s ? tk_s : tk_ns) !== 1'b1 && p < 40)
		begin
			@(negedge clk);
			p++;
		end
	endtask
	initial
	begin
		#(25 * 4000);
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rstn = 1;
		for (int b = 0; b < 2; b++)
		begin
			rdc(b[0], `SYSTK_ADDR_CSR, `SYSTK_CSR_RESET, "status reset");
			rdc(b[0], `SYSTK_ADDR_CALIB, `SYSTK_CALIB_VALUE, "calibration");
		end
		acc(1, 1, `SYSTK_ADDR_RVR, 32'hFFFFFFFF);
		rdc(1, `SYSTK_ADDR_RVR, 32'h00FFFFFF, "reload width");
		rdc(0, `SYSTK_ADDR_RVR, 32'h00000000, "reload bank");
		$display("test registers done");
		for (int b = 1; b >= 0; b--)
		begin
			acc(1, b[0], `SYSTK_ADDR_RVR, 32'(2 + 2 * b));
			acc(1, b[0], `SYSTK_ADDR_CVR, 32'h00000001);
			acc(1, b[0], `SYSTK_ADDR_CSR, 32'h00000007);
			period(b[0]);
			chk("period", 32'(p), 32'(3 + 2 * b));
			hlt = 1;
			repeat (4) @(negedge clk);
			acc(0, b[0], `SYSTK_ADDR_CVR, 0);
			v = rd;
			repeat (7) @(negedge clk);
			rdc(b[0], `SYSTK_ADDR_CVR, v, "halted count");
			rdc(b[0], `SYSTK_ADDR_CSR, 32'h00010007, "flag set");
			rdc(b[0], `SYSTK_ADDR_CSR, 32'h00000007, "flag read clear");
			hlt = 0;
			repeat (12) @(negedge clk);
			hlt = 1;
			repeat (4) @(negedge clk);
			acc(1, b[0], `SYSTK_ADDR_CVR, 32'h00ABCDEF);
			rdc(b[0], `SYSTK_ADDR_CVR, 32'h00000000, "count cleared");
			rdc(b[0], `SYSTK_ADDR_CSR, 32'h00000007, "flag write clear");
			hlt = 0;
			acc(1, b[0], `SYSTK_ADDR_CSR, 32'h00000000);
			$display("test bank %0d done", b);
		end
		acc(1, 1, `SYSTK_ADDR_CSR, 32'h00000005);
		repeat (10)
		begin
			@(negedge clk);
			chk("no tick", {31'h0, tk_s}, 32'h00000000);
		end
		acc(1, 1, `SYSTK_ADDR_CSR, 32'h00000004);
		rdc(1, `SYSTK_ADDR_CSR, 32'h00010004, "flag without irq");
		acc(0, 1, `SYSTK_ADDR_CVR, 0);
		v = rd;
		repeat (10) @(negedge clk);
		rdc(1, `SYSTK_ADDR_CVR, v, "disabled count");
		acc(1, 1, `SYSTK_ADDR_CVR, 32'h00000000);
		acc(1, 1, `SYSTK_ADDR_CSR, 32'h00000001);
		repeat (3)
		begin
			repeat (4) @(negedge clk);
			refc = 1;
			repeat (4) @(negedge clk);
			refc = 0;
		end
		repeat (6) @(negedge clk);
		rdc(1, `SYSTK_ADDR_CVR, 32'h00000002, "reference steps");
		acc(1, 1, `SYSTK_ADDR_RVR, 32'h00000000);
		acc(1, 1, `SYSTK_ADDR_CSR, 32'h00000005);
		repeat (20) @(negedge clk);
		rdc(1, `SYSTK_ADDR_CVR, 32'h00000000, "zero reload stop");
		$display("test modes done");
		report_and_stop();
	end
endmodule
